// [design/txcw_pkg.sv]
package txcw_pkg;
    // ==============================================
    // stream widths and control packet shape
    localparam int DATA_W = 32;
    localparam int KEEP_W = 4;
    localparam int CNT_W  = 16;
    localparam int IDX_W  = 3;
    localparam logic [IDX_W-1:0] WORD_FLAG = 3'h0;
    localparam logic [IDX_W-1:0] WORD_MODE = 3'h1;
    localparam logic [IDX_W-1:0] WORD_OFFS = 3'h2;
    localparam logic [IDX_W-1:0] WORD_SEED = 3'h3;
    localparam logic [IDX_W-1:0] WORD_LAST = 3'h5;
    localparam logic [IDX_W-1:0] IDX_ONE   = 3'h1;
    // ==============================================
    // control word fields
    localparam int FLAG_HI   = 31;
    localparam int FLAG_LO   = 28;
    localparam int MODE_HI   = 1;
    localparam int MODE_LO   = 0;
    localparam int START_HI  = 31;
    localparam int START_LO  = 16;
    localparam int INSERT_HI = 15;
    localparam int INSERT_LO = 0;
    localparam int SEED_HI   = 15;
    localparam int SEED_LO   = 0;
    localparam logic [3:0] FLAG_NORMAL = 4'hA;
    localparam logic [3:0] FLAG_LOOP   = 4'h5;
    localparam logic [KEEP_W-1:0] KEEP_FULL = 4'hF;
    localparam logic [KEEP_W-1:0] KEEP_TWO  = 4'h3;
    typedef enum logic [1:0] {
        CS_NONE    = 2'h0,
        CS_PARTIAL = 2'h1,
        CS_FULL    = 2'h2,
        CS_RSVD    = 2'h3
    } csum_mode_t;
    localparam int BUILD_NONE    = 0;
    localparam int BUILD_PARTIAL = 1;
    localparam int BUILD_FULL    = 2;
    // ==============================================
    // register map
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_CTRL    = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_NORMAL  = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_LOOP    = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_IGNORED = 5'h10;
    localparam logic [DATA_W-1:0] CTRL_RESET  = 32'h0000_0001;
    localparam int CTRL_OFFLOAD = 0;
    localparam int ST_STATE_LO  = 0;
    localparam int ST_MODE_LO   = 4;
    localparam int ST_LOOP      = 6;
    localparam int ST_LENERR    = 7;
    localparam int ST_FLAG_LO   = 8;
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_CTL  = 4'h2,
        S_DATA = 4'h4,
        S_SKIP = 4'h8
    } state_t;
endpackage

// [design/ctl_fields_if.sv]
`timescale 1ns/10ps
interface ctl_fields_if;
    import txcw_pkg::*;
    logic [3:0]  flag;
    logic [1:0]  checksum_mode_field;
    logic [15:0] checksum_start_offset;
    logic [15:0] checksum_insert_offset;
    logic [15:0] checksum_seed_value;
    modport producer (
        output flag, checksum_mode_field, checksum_start_offset,
               checksum_insert_offset, checksum_seed_value
    );
    modport consumer (
        input  flag, checksum_mode_field, checksum_start_offset,
               checksum_insert_offset, checksum_seed_value
    );
endinterface

// [design/ctl_word_capture.sv]
`timescale 1ns/10ps
module ctl_word_capture
    import txcw_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // accepted control word
    input  wire logic              take,
    input  wire logic [IDX_W-1:0]  idx,
    input  wire logic [DATA_W-1:0] data,
    // captured fields
    ctl_fields_if.producer         fld
);
    typedef struct packed {
        logic [3:0]  flag;
        logic [1:0]  mode;
        logic [15:0] start;
        logic [15:0] insert;
        logic [15:0] seed;
    } cap_t;

    cap_t q;
    cap_t next_q;

    // pick fields by word index
    always_comb
    begin
        next_q = q;
        if (take)
        begin
            // RQ16 fields only, rest dropped
            case (idx)
                WORD_FLAG: next_q.flag = data[FLAG_HI:FLAG_LO];
                WORD_MODE: next_q.mode = data[MODE_HI:MODE_LO];
                WORD_OFFS:
                begin
                    next_q.start  = data[START_HI:START_LO];
                    next_q.insert = data[INSERT_HI:INSERT_LO];
                end
                // RQ9 seed from low half
                WORD_SEED: next_q.seed = data[SEED_HI:SEED_LO];
                // RQ2 words four, five dropped
                default: next_q = q;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else if (ce)
            q <= next_q;
    end

    // field outputs
    assign fld.flag                   = q.flag;
    assign fld.checksum_mode_field    = q.mode;
    assign fld.checksum_start_offset  = q.start;
    assign fld.checksum_insert_offset = q.insert;
    assign fld.checksum_seed_value    = q.seed;
endmodule

// [design/keep_byte_count.sv]
`timescale 1ns/10ps
module keep_byte_count
    import txcw_pkg::*;
(
    // last-beat strobes
    input  wire logic [KEEP_W-1:0] keep,
    // right-aligned valid bytes
    output logic      [KEEP_W-1:0] keep_norm
);
    // RQ10 count from low byte
    always_comb
    begin
        logic run;
        run       = 1'b1;
        keep_norm = '0;
        for (int i = 0; i < KEEP_W; i++)
        begin
            run          = run & keep[i];
            keep_norm[i] = run;
        end
    end
endmodule

// [design/tx_stream_control_word_decoder.sv]
`timescale 1ns/10ps
// Contract
// RQ1 - control packet is six 32-bit words
// RQ2 - only words zero to three are used
// RQ3 - flag nibble selects normal or loopback
// RQ4 - mode 00 or no build: no offload
// RQ5 - partial build offloads mode 01 frames
// RQ6 - full build offloads mode 10 frames
// RQ7 - source gives even checksum start offset
// RQ8 - source gives even insert offset, eight up
// RQ9 - word three low half is seed
// RQ10 - last-beat strobes count bytes from low
// RQ11 - loopback passes following frame to mac
// RQ12 - loopback gets no offload, no vlan
// RQ13 - data waits control; control waits data
// RQ14 - source sends full words except last
// RQ15 - reserved flag packets are ignored
// RQ16 - reserved control bits are don't-care
module tx_stream_control_word_decoder
    import txcw_pkg::*;
#(
    parameter int TX_OFFLOAD_BUILD_OPTION = BUILD_FULL
)
(
    // clock, reset, enable
    input  wire logic              CLK_SYS,
    input  wire logic              RST,
    input  wire logic              CLK_EN,
    // control stream in
    input  wire logic [DATA_W-1:0] CTL_TDATA,
    input  wire logic              CTL_TVALID,
    input  wire logic              CTL_TLAST,
    output logic                   CTL_TREADY,
    // data stream in
    input  wire logic [DATA_W-1:0] TXD_TDATA,
    input  wire logic [KEEP_W-1:0] TXD_TKEEP,
    input  wire logic              TXD_TVALID,
    input  wire logic              TXD_TLAST,
    output logic                   TXD_TREADY,
    // data stream to mac transmitter
    output logic [DATA_W-1:0]      MAC_TDATA,
    output logic [KEEP_W-1:0]      MAC_TKEEP,
    output logic                   MAC_TVALID,
    output logic                   MAC_TLAST,
    input  wire logic              MAC_TREADY,
    // per-frame checksum controls
    output logic [1:0]             CHECKSUM_MODE_SELECT,
    output logic [15:0]            CHECKSUM_START_OFFSET,
    output logic [15:0]            CHECKSUM_INSERT_OFFSET,
    output logic [15:0]            CHECKSUM_SEED_VALUE,
    output logic                   FRAME_LOOPBACK,
    // register port
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [DATA_W-1:0] REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic [DATA_W-1:0]      REG_RDATA
);
    // ==============================================
    // state
    typedef struct packed {
        state_t             st;
        logic [IDX_W-1:0]   idx;
        logic               ctl_ready;
        logic               txd_ready;
        logic [DATA_W-1:0]  mac_data;
        logic [KEEP_W-1:0]  mac_keep;
        logic               mac_valid;
        logic               mac_last;
        csum_mode_t         mode;
        logic [15:0]        start;
        logic [15:0]        insert;
        logic [15:0]        seed;
        logic               loop;
        logic               len_err;
        logic [3:0]         last_flag;
        logic [DATA_W-1:0]  ctrl;
        logic [CNT_W-1:0]   n_norm;
        logic [CNT_W-1:0]   n_loop;
        logic [CNT_W-1:0]   n_ign;
        logic [DATA_W-1:0]  rdata;
    } dec_t;

    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    dec_t              q;
    dec_t              next_q;
    logic              ctl_take;
    logic              dat_take;
    logic              done;
    logic [3:0]        flag_now;
    logic [KEEP_W-1:0] keep_norm;
    logic [DATA_W-1:0] status;
    ctl_fields_if      fld ();

    assign ctl_take = CTL_TVALID & q.ctl_ready;
    assign dat_take = TXD_TVALID & q.txd_ready;

    // ==============================================
    // helpers
    ctl_word_capture u_capture (
        .clk  (CLK_SYS),
        .rst  (RST),
        .ce   (CLK_EN),
        .take (ctl_take),
        .idx  (q.idx),
        .data (CTL_TDATA),
        .fld  (fld)
    );

    keep_byte_count u_keep (
        .keep      (TXD_TKEEP),
        .keep_norm (keep_norm)
    );

    // effective offload for one frame
    function automatic csum_mode_t eff_mode(
        input logic [1:0] field,
        input logic       ok
    );
        csum_mode_t m;
        m = CS_NONE;
        // RQ5 partial build, mode 01
        if (ok && field == CS_PARTIAL &&
            TX_OFFLOAD_BUILD_OPTION == BUILD_PARTIAL)
            m = CS_PARTIAL;
        // RQ6 full build, mode 10
        else if (ok && field == CS_FULL &&
                 TX_OFFLOAD_BUILD_OPTION == BUILD_FULL)
            m = CS_FULL;
        return m;
    endfunction

    // status word layout
    always_comb
    begin
        status = '0;
        status[ST_STATE_LO +: 4] = q.st;
        status[ST_MODE_LO +: 2]  = q.mode;
        status[ST_LOOP]          = q.loop;
        status[ST_LENERR]        = q.len_err;
        status[ST_FLAG_LO +: 4]  = q.last_flag;
    end

    // ==============================================
    // next state
    always_comb
    begin
        next_q   = q;
        flag_now = (q.st == S_IDLE) ? CTL_TDATA[FLAG_HI:FLAG_LO]
                                    : fld.flag;
        done     = ctl_take & CTL_TLAST &
                   ((q.st == S_IDLE) | (q.st == S_CTL));
        next_q.rdata = '0;
        // register writes
        if (REG_WR)
        begin
            if (REG_ADDR == OFF_CTRL)
                next_q.ctrl = REG_WDATA;
        end
        // register reads, zero when unmapped
        if (REG_RD)
        begin
            if (REG_ADDR == OFF_CTRL)
                next_q.rdata = q.ctrl;
            else if (REG_ADDR == OFF_STATUS)
                next_q.rdata = status;
            else if (REG_ADDR == OFF_NORMAL)
                next_q.rdata = {{(DATA_W-CNT_W){1'b0}}, q.n_norm};
            else if (REG_ADDR == OFF_LOOP)
                next_q.rdata = {{(DATA_W-CNT_W){1'b0}}, q.n_loop};
            else if (REG_ADDR == OFF_IGNORED)
                next_q.rdata = {{(DATA_W-CNT_W){1'b0}}, q.n_ign};
        end
        // output beat leaves
        if (MAC_TREADY & q.mac_valid)
            next_q.mac_valid = 1'b0;
        case (q.st)
            S_IDLE:
            begin
                if (ctl_take & ~CTL_TLAST)
                begin
                    next_q.idx = WORD_MODE;
                    // RQ3 flag nibble routing
                    if (flag_now == FLAG_NORMAL ||
                        flag_now == FLAG_LOOP)
                        next_q.st = S_CTL;
                    // RQ15 reserved flag skipped
                    else
                        next_q.st = S_SKIP;
                end
            end
            S_CTL:
            begin
                if (ctl_take && q.idx != '1)
                    next_q.idx = q.idx + IDX_ONE;
            end
            S_SKIP:
            begin
                // RQ15 drop whole packet
                if (ctl_take & CTL_TLAST)
                begin
                    next_q.st    = S_IDLE;
                    next_q.idx   = WORD_FLAG;
                    next_q.n_ign = q.n_ign + CNT_ONE;
                end
            end
            S_DATA:
            begin
                if (dat_take)
                begin
                    next_q.mac_data  = TXD_TDATA;
                    next_q.mac_valid = 1'b1;
                    next_q.mac_last  = TXD_TLAST;
                    // RQ10 last beat byte strobes
                    next_q.mac_keep  = TXD_TLAST ? keep_norm
                                                 : KEEP_FULL;
                    if (TXD_TLAST)
                    begin
                        next_q.st  = S_IDLE;
                        next_q.idx = WORD_FLAG;
                    end
                end
            end
            default:
            begin
                next_q.st  = S_IDLE;
                next_q.idx = WORD_FLAG;
            end
        endcase
        // packet end: latch frame controls
        if (done)
        begin
            next_q.last_flag = flag_now;
            // RQ1 six words expected
            next_q.len_err   = (q.idx != WORD_LAST);
            next_q.idx       = WORD_FLAG;
            next_q.loop      = (flag_now == FLAG_LOOP);
            // RQ4 off unless mode and build agree
            next_q.mode      = eff_mode(fld.checksum_mode_field,
                                        q.st == S_CTL &&
                                        q.ctrl[CTRL_OFFLOAD] &&
                                        flag_now == FLAG_NORMAL);
            // RQ12 loopback gets no offload fields
            next_q.start     = '0;
            next_q.insert    = '0;
            next_q.seed      = '0;
            if (flag_now == FLAG_NORMAL && q.st == S_CTL)
            begin
                next_q.start  = fld.checksum_start_offset;
                next_q.insert = fld.checksum_insert_offset;
                next_q.seed   = fld.checksum_seed_value;
            end
            if (flag_now == FLAG_NORMAL)
            begin
                next_q.st     = S_DATA;
                next_q.n_norm = q.n_norm + CNT_ONE;
            end
            // RQ11 loopback frame follows
            else if (flag_now == FLAG_LOOP)
            begin
                next_q.st     = S_DATA;
                next_q.n_loop = q.n_loop + CNT_ONE;
            end
            else
            begin
                next_q.st    = S_IDLE;
                next_q.n_ign = q.n_ign + CNT_ONE;
            end
        end
        // RQ13 one channel open at a time
        next_q.ctl_ready = (next_q.st != S_DATA) & ~next_q.mac_valid;
        next_q.txd_ready = (next_q.st == S_DATA) & ~next_q.mac_valid;
    end

    // state register
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            q           <= '0;
            q.st        <= S_IDLE;
            q.mode      <= CS_NONE;
            q.ctrl      <= CTRL_RESET;
            q.ctl_ready <= 1'b1;
        end
        else if (CLK_EN)
            q <= next_q;
    end

    // ==============================================
    // outputs
    assign CTL_TREADY             = q.ctl_ready;
    assign TXD_TREADY             = q.txd_ready;
    assign MAC_TDATA              = q.mac_data;
    assign MAC_TKEEP              = q.mac_keep;
    assign MAC_TVALID             = q.mac_valid;
    assign MAC_TLAST              = q.mac_last;
    assign CHECKSUM_MODE_SELECT   = q.mode;
    assign CHECKSUM_START_OFFSET  = q.start;
    assign CHECKSUM_INSERT_OFFSET = q.insert;
    assign CHECKSUM_SEED_VALUE    = q.seed;
    assign FRAME_LOOPBACK         = q.loop;
    assign REG_RDATA              = q.rdata;

    // ==============================================
    // assertions
    sequence s_normal_done;
        CLK_EN && done && flag_now == FLAG_NORMAL && q.st == S_CTL;
    endsequence

    sequence s_loop_done;
        CLK_EN && done && flag_now == FLAG_LOOP;
    endsequence

    property p_six_words;
        @(posedge CLK_SYS) disable iff (RST)
        (CLK_EN && done && q.idx == WORD_LAST) |=> !q.len_err;
    endproperty
    a_six_words: assert property (p_six_words) // RQ1
        else $error("six word packet flagged short");

    property p_tail_ignored;
        @(posedge CLK_SYS) disable iff (RST)
        (CLK_EN && ctl_take && q.st == S_CTL && q.idx > WORD_SEED)
        |=> $stable(fld.checksum_seed_value) &&
            $stable(fld.checksum_start_offset);
    endproperty
    a_tail_ignored: assert property (p_tail_ignored) // RQ2
        else $error("word four or five changed a field");

    property p_flag_route;
        @(posedge CLK_SYS) disable iff (RST)
        (CLK_EN && ctl_take && q.st == S_IDLE && !CTL_TLAST &&
         CTL_TDATA[FLAG_HI:FLAG_LO] == FLAG_NORMAL)
        |=> q.st == S_CTL && q.idx == WORD_MODE;
    endproperty
    a_flag_route: assert property (p_flag_route) // RQ3
        else $error("normal flag not routed to control words");

    property p_mode_none;
        @(posedge CLK_SYS) disable iff (RST)
        (CLK_EN && done && fld.checksum_mode_field == CS_NONE)
        |=> q.mode == CS_NONE;
    endproperty
    a_mode_none: assert property (p_mode_none) // RQ4
        else $error("offload set for mode none");

    property p_partial;
        @(posedge CLK_SYS) disable iff (RST)
        s_normal_done ##0 (fld.checksum_mode_field == CS_PARTIAL &&
            q.ctrl[CTRL_OFFLOAD])
        |=> q.mode == ((TX_OFFLOAD_BUILD_OPTION == BUILD_PARTIAL) ?
                       CS_PARTIAL : CS_NONE);
    endproperty
    a_partial: assert property (p_partial) // RQ5
        else $error("partial offload not selected");

    property p_full;
        @(posedge CLK_SYS) disable iff (RST)
        s_normal_done ##0 (fld.checksum_mode_field == CS_FULL &&
            q.ctrl[CTRL_OFFLOAD] &&
            TX_OFFLOAD_BUILD_OPTION == BUILD_FULL)
        |=> q.mode == CS_FULL;
    endproperty
    a_full: assert property (p_full) // RQ6
        else $error("full offload not selected");

    property p_seed;
        @(posedge CLK_SYS) disable iff (RST)
        s_normal_done |=> q.seed == $past(fld.checksum_seed_value);
    endproperty
    a_seed: assert property (p_seed) // RQ9
        else $error("seed not taken from word three");

    property p_last_keep;
        @(posedge CLK_SYS) disable iff (RST)
        (CLK_EN && dat_take && TXD_TLAST && TXD_TKEEP == KEEP_TWO)
        |=> q.mac_keep == KEEP_TWO && q.mac_last && q.mac_valid;
    endproperty
    a_last_keep: assert property (p_last_keep) // RQ10
        else $error("last beat strobes not passed");

    property p_loop_pass;
        @(posedge CLK_SYS) disable iff (RST)
        s_loop_done |=> q.st == S_DATA && q.loop;
    endproperty
    a_loop_pass: assert property (p_loop_pass) // RQ11
        else $error("loopback frame not opened");

    property p_loop_plain;
        @(posedge CLK_SYS) disable iff (RST)
        q.loop |-> q.mode == CS_NONE;
    endproperty
    a_loop_plain: assert property (p_loop_plain) // RQ12
        else $error("offload on loopback frame");

    property p_gate;
        @(posedge CLK_SYS) disable iff (RST)
        (q.st != S_DATA |-> !q.txd_ready) and
        (q.st == S_DATA |-> !q.ctl_ready);
    endproperty
    a_gate: assert property (p_gate) // RQ13
        else $error("both stream channels open");

    property p_skip;
        @(posedge CLK_SYS) disable iff (RST)
        (CLK_EN && q.st == S_SKIP && ctl_take && CTL_TLAST)
        |=> q.st == S_IDLE && !q.txd_ready;
    endproperty
    a_skip: assert property (p_skip) // RQ15
        else $error("reserved packet opened data");
endmodule

// [test/stream_source.sv]
`timescale 1ns/10ps
module stream_source
    import txcw_pkg::*;
(
    // clock
    input  wire logic              clk,
    // control stream
    output logic      [DATA_W-1:0] ctl_tdata,
    output logic                   ctl_tvalid,
    output logic                   ctl_tlast,
    input  wire logic              ctl_tready,
    // frame data stream
    output logic      [DATA_W-1:0] txd_tdata,
    output logic      [KEEP_W-1:0] txd_tkeep,
    output logic                   txd_tvalid,
    output logic                   txd_tlast,
    input  wire logic              txd_tready
);
    // idle values at time zero
    initial
    begin
        {ctl_tdata, ctl_tvalid, ctl_tlast} = '0;
        {txd_tdata, txd_tkeep, txd_tvalid, txd_tlast} = '0;
    end

    task automatic send_ctl(input logic [DATA_W-1:0] w [6]);
        for (int i = 0; i < 6; i++)
        begin
            ctl_tdata  <= w[i];
            ctl_tlast  <= (i == 5);
            ctl_tvalid <= 1'b1;
            @(posedge clk);
            while (ctl_tready !== 1'b1)
                @(posedge clk);
        end
        // released bus shows inverted word
        ctl_tdata  <= ~w[5];
        ctl_tvalid <= 1'b0;
        ctl_tlast  <= 1'b0;
    endtask

    task automatic send_frame(input int n, input logic [KEEP_W-1:0] keep);
        for (int i = 0; i < n; i++)
        begin
            txd_tdata  <= 32'hD000_0000 + DATA_W'(i);
            txd_tkeep  <= (i == n - 1) ? keep : KEEP_FULL;
            txd_tlast  <= (i == n - 1);
            txd_tvalid <= 1'b1;
            @(posedge clk);
            while (txd_tready !== 1'b1)
                @(posedge clk);
        end
        txd_tdata  <= ~txd_tdata;
        txd_tkeep  <= ~keep;
        txd_tvalid <= 1'b0;
        txd_tlast  <= 1'b0;
    endtask
endmodule

// [test/tx_stream_control_word_decoder_tb.sv]
`timescale 1ns/10ps
module tx_stream_control_word_decoder_tb;
    import txcw_pkg::*;
    logic        CLK_SYS, RST, CLK_EN, MAC_TREADY, stall;
    logic        CTL_TVALID, CTL_TLAST, CTL_TREADY, FRAME_LOOPBACK;
    logic        TXD_TVALID, TXD_TLAST, TXD_TREADY, MAC_TVALID, MAC_TLAST;
    logic [31:0] CTL_TDATA, TXD_TDATA, MAC_TDATA, REG_WDATA, REG_RDATA, r;
    logic [3:0]  TXD_TKEEP, MAC_TKEEP;
    logic [1:0]  CHECKSUM_MODE_SELECT;
    logic [15:0] CHECKSUM_START_OFFSET, CHECKSUM_INSERT_OFFSET;
    logic [15:0] CHECKSUM_SEED_VALUE;
    logic [4:0]  REG_ADDR;
    logic        REG_WR, REG_RD;
    logic [36:0] macq [$];
    int          n_fail, checks_done;

    tx_stream_control_word_decoder #(.TX_OFFLOAD_BUILD_OPTION(BUILD_FULL))
    tx_stream_control_word_decoder_i (
        .CLK_SYS(CLK_SYS), .RST(RST), .CLK_EN(CLK_EN),
        .CTL_TDATA(CTL_TDATA), .CTL_TVALID(CTL_TVALID),
        .CTL_TLAST(CTL_TLAST), .CTL_TREADY(CTL_TREADY),
        .TXD_TDATA(TXD_TDATA), .TXD_TKEEP(TXD_TKEEP),
        .TXD_TVALID(TXD_TVALID), .TXD_TLAST(TXD_TLAST),
        .TXD_TREADY(TXD_TREADY), .MAC_TDATA(MAC_TDATA),
        .MAC_TKEEP(MAC_TKEEP), .MAC_TVALID(MAC_TVALID),
        .MAC_TLAST(MAC_TLAST), .MAC_TREADY(MAC_TREADY),
        .CHECKSUM_MODE_SELECT(CHECKSUM_MODE_SELECT),
        .CHECKSUM_START_OFFSET(CHECKSUM_START_OFFSET),
        .CHECKSUM_INSERT_OFFSET(CHECKSUM_INSERT_OFFSET),
        .CHECKSUM_SEED_VALUE(CHECKSUM_SEED_VALUE),
        .FRAME_LOOPBACK(FRAME_LOOPBACK), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA));

    stream_source stream_source_i (
        .clk(CLK_SYS), .ctl_tdata(CTL_TDATA), .ctl_tvalid(CTL_TVALID),
        .ctl_tlast(CTL_TLAST), .ctl_tready(CTL_TREADY),
        .txd_tdata(TXD_TDATA), .txd_tkeep(TXD_TKEEP),
        .txd_tvalid(TXD_TVALID), .txd_tlast(TXD_TLAST),
        .txd_tready(TXD_TREADY));

    // clock
    initial
    begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end

    // mac sink, toggling ready when stalling
    always @(posedge CLK_SYS)
    begin
        MAC_TREADY <= stall ? ~MAC_TREADY : 1'b1;
        if (MAC_TVALID === 1'b1 && MAC_TREADY === 1'b1)
            macq.push_back({MAC_TLAST, MAC_TKEEP, MAC_TDATA});
    end

    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("fails %0d checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CLK_SYS);
        REG_WR    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [4:0] a, output logic [31:0] d);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CLK_SYS);
        REG_RD   <= 1'b0;
        #1;
        d = REG_RDATA;
        @(posedge CLK_SYS);
    endtask

    // one control packet, its frame, and all checks
    task automatic do_frame(input logic [3:0] flag, input logic [1:0] mode,
        input logic [1:0] want, input logic lp, input logic [3:0] keep);
        logic [31:0] w [6];
        w = '{{flag, 28'hFFF_FFFF}, {30'h3FFF_FFFF, mode}, 32'h0012_0036,
              32'hFFFF_BEEF, 32'hDEAD_0004, 32'hDEAD_0005};
        macq.delete();
        stream_source_i.send_ctl(w);
        @(posedge CLK_SYS);
        #1;
        check(CTL_TREADY, 1'b0);
        check(TXD_TREADY, 1'b1);
        check(CHECKSUM_MODE_SELECT, want);
        check(FRAME_LOOPBACK, lp);
        if (lp || want != 2'b00)
        begin
            check(CHECKSUM_START_OFFSET, lp ? 16'h0000 : 16'h0012);
            check(CHECKSUM_INSERT_OFFSET, lp ? 16'h0000 : 16'h0036);
            check(CHECKSUM_SEED_VALUE, lp ? 16'h0000 : 16'hBEEF);
        end
        @(posedge CLK_SYS);
        stream_source_i.send_frame(3, keep);
        for (int i = 0; i < 40 && (macq.size() < 3 || !CTL_TREADY); i++)
            @(posedge CLK_SYS);
        check(macq.size(), 3);
        check(CTL_TREADY, 1'b1);
        for (int i = 0; i < macq.size(); i++)
        begin
            check(macq[i][31:0], 32'hD000_0000 + i);
            check(macq[i][36:32], (i == 2) ? {1'b1, keep} : 5'h0F);
        end
    endtask

    // reset release, ready levels, register reads
    task automatic after_reset;
        repeat (4) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        #1;
        check(CTL_TREADY, 1'b1);
        check(TXD_TREADY, 1'b0);
        @(posedge CLK_SYS);
        reg_rd(OFF_CTRL, r);
        check(r, CTRL_RESET);
        reg_rd(5'h14, r);
        check(r, 32'h0000_0000);
    endtask

    // undefined flags dropped, one edge between packets
    task automatic skip_reserved;
        for (int i = 0; i < 3; i++)
        begin
            stream_source_i.send_ctl('{{4'h3 << i, 28'h0}, 32'h2,
                32'h0, 32'h0, 32'h0, 32'h0});
            @(posedge CLK_SYS);
        end
        repeat (3) @(posedge CLK_SYS);
        check(TXD_TREADY, 1'b0);
        check(CTL_TREADY, 1'b1);
    endtask

    // frame counters over the register port
    task automatic count_frames;
        reg_rd(OFF_NORMAL, r);
        check(r, 32'h0000_0005);
        reg_rd(OFF_LOOP, r);
        check(r, 32'h0000_0001);
        reg_rd(OFF_IGNORED, r);
        check(r, 32'h0000_0003);
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        {RST, CLK_EN, MAC_TREADY, stall} = 4'b1100;
        {REG_ADDR, REG_WDATA, REG_WR, REG_RD} = '0;
        n_fail = 0;
        checks_done = 0;
        after_reset();
        do_frame(FLAG_NORMAL, 2'b10, 2'b10, 1'b0, 4'h3);
        do_frame(FLAG_NORMAL, 2'b00, 2'b00, 1'b0, 4'h1);
        do_frame(FLAG_NORMAL, 2'b11, 2'b00, 1'b0, 4'h7);
        do_frame(FLAG_NORMAL, 2'b01, 2'b00, 1'b0, 4'h7);
        reg_wr(OFF_CTRL, 32'h0000_0000);
        do_frame(FLAG_NORMAL, 2'b10, 2'b00, 1'b0, 4'hF);
        reg_wr(OFF_CTRL, 32'h0000_0001);
        stall <= 1'b1;
        do_frame(FLAG_LOOP, 2'b10, 2'b00, 1'b1, 4'h3);
        stall <= 1'b0;
        skip_reserved();
        count_frames();
        end_of_test();
    end

    // watchdog
    initial
    begin
        repeat (5000) @(posedge CLK_SYS);
        n_fail++;
        end_of_test();
    end
endmodule
